// file: rxs_consts.svh
`ifndef RXS_CONSTS_SVH
`define RXS_CONSTS_SVH
`define RXS_ADDR_CTRL      4'h0
`define RXS_ADDR_STATUS    4'h1
`define RXS_ADDR_LASTWORD  4'h2
`define RXS_CTRL_RECEIVE_ENABLE_BIT_BIT  0
`define RXS_CTRL_PASS_BIT  1
`define RXS_CTRL_RESET     2'h0
`define RXS_ST_HALTED_BIT  0
`define RXS_ST_ERR_BIT     1
`define RXS_ST_INFRAME_BIT 2
`define RXS_MAX_FRAME      14'd1518
`define RXS_RUNT_LEN       14'd64
`define RXS_TYPE_MIN_LEN   14'd14
`define RXS_WDOG_LEN       14'd2048
`define RXS_TYPE_THRESH    16'h05DC
`define RXS_BCAST_ADDR     48'hFFFFFFFFFFFF
`endif

// file: rxs_host_model.sv
`timescale 1ns/1ps
module rxs_host_model #(parameter int DEPTH = 2) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        push,
   input  wire logic        pop,
   input  wire logic [31:0] word,
   output logic             full = 1'b0,
   output logic             underrun = 1'b0
);
   // status words queue apart from frame data
   logic [31:0] q[$];
   always @(posedge clk) begin
      underrun <= 1'b0;
      if (rst) begin
         q.delete(); // soft reset resyncs the host
      end else begin
         if (pop && q.size() == 0) begin
            underrun <= 1'b1; // host reads past the end
         end else if (pop) begin
            void'(q.pop_front()); // optional flush by reading
         end
         // a full queue drops the word, as the real one would
         if (push && q.size() < DEPTH) q.push_back(word);
      end
      full <= q.size() >= DEPTH;
   end
endmodule

// file: rxs_pkg.sv
package rxs_pkg;
   // per-frame facts reported by the receive datapath at frame end
   typedef struct packed {
      logic [13:0] length;
      logic [47:0] destAddr;
      logic [15:0] lenType;
      logic        filterFail;
      logic        lateCollision;
      logic        rxErrSeen;
      logic        crcMismatch;
      logic [2:0]  dribbleBits;
      logic        mode10;
   } rxs_frame_type;
   typedef enum logic [1:0] {RUNNING, DRAINING, HALTED} rxs_state_type;
endpackage

// file: rxs_rx_status.sv
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "rxs_consts.svh"
// Behaviour
// - reserved status bits 31, 14, 9:8 and 0 always read zero
// - bit 30 set when frame failed the address filter
// - bits 29:16 carry the frame length in bytes
// - bit 15 is OR of bits 11, 7, 6 and 1
// - bit 13 set for broadcast destination
// - bit 12 set when an 802.3 length field (1500 or under) differs from frame length minus 18, for frames of 14 bytes or more
// - bit 11 marks frames under 64 bytes; passed only if pass-bad set
// - bit 10 set for multicast destination
// - bit 7 flags frames over 1518 bytes, no truncation
// - bit 6 marks a late collision
// - bit 5 set when length/type over 1500, never for runts under 14
// - bit 4 set when frame hits the receive watchdog limit
// - bit 3 set when receive error seen during frame
// - bit 2 set for non-whole-byte frame length
// - dribble needs 4 bits MII or 3 bits 10M; off on late collision
// - bit 1 set on CRC mismatch or receive error
// - clearing enable halts receiver, then one halted pulse
// - error flag on data/status underrun or status overrun
// - receiver keeps running after the error flag is raised
// - status word written to its own FIFO after frame data
module rxs_rx_status (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic [3:0]            regAddr,
   input  wire logic [31:0]           regWrData,
   input  wire logic                  regWrEn,
   input  wire logic                  regRdEn,
   output logic [31:0]                regRdData,
   input  wire logic                  frameStart,
   input  wire logic                  frameEnd,
   input  wire rxs_pkg::rxs_frame_type frameInfo,
   input  wire logic                  dataDone,
   input  wire logic                  dataUnderrun,
   input  wire logic                  statusUnderrun,
   input  wire logic                  statusFull,
   output logic                       statusWrite,
   output logic [31:0]                statusWord,
   output logic                       frameAccept,
   output logic                       receiveEnable,
   output logic                       receiverHaltedPulse,
   output logic                       receiverErrorFlag
);
   import rxs_pkg::*;

   logic [1:0]    ctrl_q, ctrl_d;
   rxs_state_type state_q, state_d;
   logic          inFrame_q, inFrame_d;
   logic          haltPulse_q, haltPulse_d;
   logic          err_q, err_d;
   logic          stWr_q, stWr_d;
   logic [31:0]   stWord_q, stWord_d;
   logic          accept_q, accept_d;
   logic          pend_q, pend_d;
   logic [31:0]   pendWord_q, pendWord_d;
   logic          pendAcc_q, pendAcc_d;
   logic [31:0]   rdData_q, rdData_d;
   logic [31:0]   word;
   logic          runt, tooLong, lateCol, crcErr, dribble, typeBit, lenErr;
   logic          bcast, mcast, wdog;
   logic [13:0]   fieldLen;

   // status word assembly
   always_comb begin
      runt     = frameInfo.length < `RXS_RUNT_LEN;
      tooLong  = frameInfo.length > `RXS_MAX_FRAME;
      lateCol  = frameInfo.lateCollision;
      wdog     = frameInfo.length >= `RXS_WDOG_LEN;
      crcErr   = frameInfo.crcMismatch | frameInfo.rxErrSeen;
      dribble  = !lateCol && (frameInfo.mode10 ? (frameInfo.dribbleBits >= 3'h3)
                                              : (frameInfo.dribbleBits == 3'h4));
      typeBit  = !(frameInfo.length < `RXS_TYPE_MIN_LEN)
                 && (frameInfo.lenType > `RXS_TYPE_THRESH);
      fieldLen = frameInfo.lenType[13:0];
      // length check only for 802.3 frames; payload is length minus header and crc
      lenErr   = !typeBit && (frameInfo.length >= `RXS_TYPE_MIN_LEN)
                 && (fieldLen != frameInfo.length - 14'd18);
      bcast    = frameInfo.destAddr == `RXS_BCAST_ADDR;
      mcast    = frameInfo.destAddr[40] && !bcast;
      word     = 32'h0;
      word[30]    = frameInfo.filterFail;
      word[29:16] = frameInfo.length;
      word[15]    = runt | tooLong | lateCol | crcErr;
      word[13]    = bcast;
      word[12]    = lenErr;
      word[11]    = runt;
      word[10]    = mcast;
      word[7]     = tooLong;
      word[6]     = lateCol;
      word[5]     = typeBit;
      word[4]     = wdog;
      word[3]     = frameInfo.rxErrSeen;
      word[2]     = dribble;
      word[1]     = crcErr;
   end

   // control, stop sequencing, status queueing
   always_comb begin
      ctrl_d      = ctrl_q;
      state_d     = state_q;
      inFrame_d   = inFrame_q;
      haltPulse_d = 1'b0;
      err_d       = err_q;
      stWr_d      = 1'b0;
      stWord_d    = stWord_q;
      accept_d    = accept_q;
      pend_d      = pend_q;
      pendWord_d  = pendWord_q;
      pendAcc_d   = pendAcc_q;
      rdData_d    = 32'h0;
      if (regWrEn && regAddr == `RXS_ADDR_CTRL) begin
         ctrl_d = regWrData[1:0];
      end
      if (frameStart && state_q == RUNNING) begin
         inFrame_d = 1'b1;
      end
      if (frameEnd && inFrame_q) begin
         inFrame_d  = 1'b0;
         // held until the data side reports its last transfer
         pend_d     = 1'b1;
         pendWord_d = word;
         pendAcc_d  = !runt || ctrl_q[`RXS_CTRL_PASS_BIT];
      end
      if (pend_q && dataDone) begin
         pend_d   = 1'b0;
         stWr_d   = pendAcc_q;
         stWord_d = pendWord_q;
         accept_d = pendAcc_q;
      end
      unique case (state_q)
         RUNNING: begin
            if (!ctrl_q[`RXS_CTRL_RECEIVE_ENABLE_BIT_BIT]) begin
               state_d = DRAINING;
            end
         end
         DRAINING: begin
            if (!inFrame_q && !pend_q) begin
               state_d     = HALTED;
               haltPulse_d = 1'b1;
            end
         end
         HALTED: begin
            if (ctrl_q[`RXS_CTRL_RECEIVE_ENABLE_BIT_BIT]) begin
               state_d = RUNNING;
            end
         end
      endcase
      // sticky; no halt follows, host decides recovery
      if (dataUnderrun || statusUnderrun || (stWr_d && statusFull)) begin
         err_d = 1'b1;
      end else if (regWrEn && regAddr == `RXS_ADDR_STATUS
                   && regWrData[`RXS_ST_ERR_BIT]) begin
         err_d = 1'b0;
      end
      if (regRdEn) begin
         unique case (regAddr)
            `RXS_ADDR_CTRL:     rdData_d = {30'h0, ctrl_q};
            `RXS_ADDR_STATUS:   rdData_d = {29'h0, inFrame_q, err_q, state_q == HALTED};
            `RXS_ADDR_LASTWORD: rdData_d = stWord_q;
            default:            rdData_d = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q      <= `RXS_CTRL_RESET;
         state_q     <= HALTED;
         inFrame_q   <= 1'b0;
         haltPulse_q <= 1'b0;
         err_q       <= 1'b0;
         stWr_q      <= 1'b0;
         stWord_q    <= 32'h0;
         accept_q    <= 1'b0;
         pend_q      <= 1'b0;
         pendWord_q  <= 32'h0;
         pendAcc_q   <= 1'b0;
         rdData_q    <= 32'h0;
      end else begin
         ctrl_q      <= ctrl_d;
         state_q     <= state_d;
         inFrame_q   <= inFrame_d;
         haltPulse_q <= haltPulse_d;
         err_q       <= err_d;
         stWr_q      <= stWr_d;
         stWord_q    <= stWord_d;
         accept_q    <= accept_d;
         pend_q      <= pend_d;
         pendWord_q  <= pendWord_d;
         pendAcc_q   <= pendAcc_d;
         rdData_q    <= rdData_d;
      end
   end

   assign regRdData           = rdData_q;
   assign statusWrite         = stWr_q;
   assign statusWord          = stWord_q;
   assign frameAccept         = accept_q;
   assign receiveEnable       = state_q != HALTED;
   assign receiverHaltedPulse = haltPulse_q;
   assign receiverErrorFlag   = err_q;
endmodule

// file: rxs_rx_status_asserts.sv
`timescale 1ns/1ps
module rxs_rx_status_asserts (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        dataUnderrun,
   input wire logic        statusUnderrun,
   input wire logic        statusWrite,
   input wire logic [31:0] statusWord,
   input wire logic        receiveEnable,
   input wire logic        receiverHaltedPulse,
   input wire logic        receiverErrorFlag
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire logic [13:0] len = statusWord[29:16];
   resv_zero_a:
      assert property (statusWrite |-> {statusWord[31], statusWord[14], statusWord[9:8],
         statusWord[0]} == 5'h0) else $error("reserved bit set");
   err_summary_a:
      assert property (statusWrite |-> statusWord[15] == (statusWord[11] | statusWord[7]
         | statusWord[6] | statusWord[1])) else $error("summary bit wrong");
   runt_flag_a:
      assert property (statusWrite |-> statusWord[11] == (len < 14'h40)) else $error("runt");
   too_long_a:
      assert property (statusWrite |-> statusWord[7] == (len > 14'h5EE)) else $error("long");
   short_type_a:
      assert property (statusWrite && len < 14'hE |-> !statusWord[5]) else $error("type");
   wdog_flag_a:
      assert property (statusWrite |-> statusWord[4] == (len >= 14'h800)) else $error("wdog");
   dribble_late_a:
      assert property (statusWrite && statusWord[6] |-> !statusWord[2]) else $error("dribble");
   halt_pulse_a:
      assert property (receiverHaltedPulse |=> !receiverHaltedPulse && !receiveEnable)
         else $error("halted pulse");
   err_set_a:
      assert property (dataUnderrun || statusUnderrun |=> receiverErrorFlag) else $error("err");
   keep_running_a:
      assert property ($rose(receiverErrorFlag) |-> $stable(receiveEnable)) else $error("run");
   cover property (statusWrite && statusWord[11]);
   cover property (receiverHaltedPulse);
   cover property ($rose(receiverErrorFlag));
endmodule
bind rxs_rx_status rxs_rx_status_asserts chk (.*);

// file: tb.sv
`timescale 1ns/1ps
`include "rxs_consts.svh"
module tb;
   import rxs_pkg::*;
   logic clk = 0, rst = 1, regWrEn = 0, regRdEn = 0, frameStart = 0, frameEnd = 0;
   logic dataDone = 0, dataUnderrun = 0, pop = 0;
   logic [3:0] regAddr = 4'h0;
   logic [31:0] regWrData = 32'h0, regRdData, statusWord, lastWord, rdv;
   rxs_frame_type frameInfo = '0;
   logic statusWrite, frameAccept, receiveEnable, receiverHaltedPulse, receiverErrorFlag;
   logic statusFull, statusUnderrun;
   int err_total = 0, check_count = 0, pushes = 0, seed = 32'h3394, n;
   logic [13:0] lens [8] = '{14'hD, 14'hE, 14'h3F, 14'h40, 14'h5EE, 14'h5EF, 14'h7FF, 14'h800};
   always #2.5 clk = ~clk;
   always @(posedge clk) if (statusWrite) begin lastWord <= statusWord; pushes <= pushes + 1; end
   rxs_rx_status DUT (.*);
   rxs_host_model host (.clk, .rst, .push(statusWrite), .pop, .word(statusWord),
      .full(statusFull), .underrun(statusUnderrun));
   task chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin err_total++; $display("wrong value %0t got %h exp %h", $time, g, e); end
   endtask
   task complete_run;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk) begin regAddr <= a; regWrData <= d; regWrEn <= 1'b1; end
      @(posedge clk) regWrEn <= 1'b0;
   endtask
   task rd(input logic [3:0] a);
      @(posedge clk) begin regAddr <= a; regRdEn <= 1'b1; end
      @(posedge clk) regRdEn <= 1'b0;
      #1 rdv = regRdData;
   endtask
   function logic [31:0] expw(input rxs_frame_type f);
      logic [31:0] w;
      w = '0;
      w[30] = f.filterFail;
      w[29:16] = f.length;
      w[13] = f.destAddr == `RXS_BCAST_ADDR;
      // frames shorter than the header carry no length field to compare
      w[12] = f.lenType <= 16'h05DC && f.length >= 14'hE
              && f.lenType != {2'h0, f.length} - 16'h0012;
      w[11] = f.length < 14'h40;
      w[10] = f.destAddr[40] && !w[13];
      w[7] = f.length > 14'h5EE;
      w[6] = f.lateCollision;
      w[5] = f.lenType > 16'h05DC && f.length >= 14'hE;
      w[4] = f.length >= 14'h800;
      w[3] = f.rxErrSeen;
      w[2] = (f.mode10 ? f.dribbleBits >= 3'h3 : f.dribbleBits == 3'h4) && !f.lateCollision;
      w[1] = f.crcMismatch || f.rxErrSeen;
      w[15] = w[11] | w[7] | w[6] | w[1];
      return w;
   endfunction
   task frm(input rxs_frame_type f, input logic ok, input logic take);
      int p0;
      p0 = pushes;
      @(posedge clk) frameStart <= 1'b1;
      @(posedge clk) begin frameStart <= 1'b0; frameEnd <= 1'b1; frameInfo <= f; end
      @(posedge clk) begin frameEnd <= 1'b0; dataDone <= 1'b1; end
      @(posedge clk) dataDone <= 1'b0;
      repeat (3) @(posedge clk);
      chk(32'(pushes - p0), {31'h0, ok});
      if (ok) chk(lastWord, expw(f));
      if (ok) chk({31'h0, frameAccept}, 32'h1);
      if (take) begin pop <= 1'b1; @(posedge clk) pop <= 1'b0; end
   endtask
   task errchk;
      repeat (2) @(posedge clk);
      rd(4'h1); chk({31'h0, rdv[1]}, 32'h1);
      chk({31'h0, receiveEnable}, 32'h1);
      wr(4'h1, 32'h2);
      rd(4'h1); chk({31'h0, rdv[1]}, 32'h0);
   endtask
   initial begin
      logic [95:0] r;
      rxs_frame_type f;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd(4'h0); chk(rdv, 32'h0);
      rd(4'hF); chk(rdv, 32'h0);
      wr(4'h0, 32'h3);
      for (n = 0; n < 40; n++) begin
         r = {$random(seed), $random(seed), $random(seed)};
         f = r[85:0];
         f.length = n < 8 ? lens[n] : 14'($unsigned($random(seed)) % 2600);
         if (n % 4 == 0) f.destAddr = `RXS_BCAST_ADDR;
         if (!n[0]) f.lenType = {2'h0, f.length} - 16'h0012;
         frm(f, 1'b1, 1'b1);
      end
      wr(4'h0, 32'h1);
      f.length = 14'h28; frm(f, 1'b0, 1'b0);
      chk({31'h0, frameAccept}, 32'h0);
      f.length = 14'h9C4; frm(f, 1'b1, 1'b0);
      frm(f, 1'b1, 1'b0);
      frm(f, 1'b1, 1'b0);
      errchk;
      @(posedge clk) pop <= 1'b1;
      repeat (3) @(posedge clk);
      pop <= 1'b0;
      errchk;
      @(posedge clk) dataUnderrun <= 1'b1;
      @(posedge clk) dataUnderrun <= 1'b0;
      errchk;
      wr(4'h0, 32'h0);
      n = 0;
      while (receiverHaltedPulse !== 1'b1 && n < 50) begin @(posedge clk); #1 n++; end
      chk({31'h0, receiverHaltedPulse}, 32'h1);
      @(posedge clk); #1 chk({31'h0, receiveEnable}, 32'h0);
      frm(f, 1'b0, 1'b0);
      wr(4'h0, 32'h1);
      frm(f, 1'b1, 1'b1);
      complete_run;
   end
   initial begin
      #100000;
      err_total++;
      complete_run;
   end
endmodule
